// *** hw/sarlv_defines.svh ***
// Constants of the SAR converter control and serial readout block.
// Assumes sys_clk at 250 MHz; included by bare name from the hw folder.
`ifndef SARLV_DEFINES_SVH
`define SARLV_DEFINES_SVH

// Clock and timing
`define SARLV_CLK_PERIOD_PS 4000
`define SARLV_CONV_TIME_NS 101
`define SARLV_CONV_CYCLES ((`SARLV_CONV_TIME_NS * 1000) / `SARLV_CLK_PERIOD_PS)
`define SARLV_SETTLE_TIME_MS 20
`define SARLV_SETTLE_CYCLES ((`SARLV_SETTLE_TIME_MS * 64'd1000000000) / `SARLV_CLK_PERIOD_PS)

// Result word and buffering
`define SARLV_WORD_W 16
`define SARLV_FIFO_DEPTH 16
`define SARLV_INVALID_COUNT 2'h2

// Readout bursts, counted in falling edges of the readout clock
`define SARLV_LAST_PULSE_SINGLE 3'h7
`define SARLV_LAST_PULSE_DUAL 3'h3

// Fixed test words
`define SARLV_PATTERN_SINGLE 16'ha07f
`define SARLV_PATTERN_DUAL 16'hcc3f

// Positions in the synchronised pin vector
`define SARLV_PIN_SLEEP_N 0
`define SARLV_PIN_SUPPLY 1
`define SARLV_PIN_CONVERT 2
`define SARLV_PIN_DUAL 3
`define SARLV_PIN_PATTERN 4
`define SARLV_PIN_CONVERT_N 5
`define SARLV_PIN_COUNT 6

`endif

// *** hw/sarlv_pkg.sv ***
// Types shared by the SAR converter control block.
// Holds no constants; those live in sarlv_defines.svh.
package sarlv_pkg;

   typedef enum logic [3:0] {
      SARLV_ST_OFF = 4'h1,
      SARLV_ST_IDLE = 4'h2,
      SARLV_ST_CONV = 4'h4,
      SARLV_ST_PUSH = 4'h8
   } sarlv_state_t;

endpackage

// *** hw/sarlv_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sarlv_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic [AW:0] wr_ptr_next;
   logic [AW:0] rd_ptr_next;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign push = in_valid & ~full;
   assign pop = out_ready & ~empty;
   assign wr_ptr_next = push ? wr_ptr_reg + (AW+1)'(1) : wr_ptr_reg;
   assign rd_ptr_next = pop ? rd_ptr_reg + (AW+1)'(1) : rd_ptr_reg;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
      end
   end

   // Storage needs no reset; empty flag guards stale entries
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

endmodule

// *** hw/sarlv_top.sv ***
// Conversion control and double-data-rate serial readout of a 16-bit SAR converter.
// Assumes an analog core that presents its decided code on sample_code and a host
// that supplies bursts on readout_clk and keeps its own timing obligations.
//
// Operation
// - Sleep input low: all off, converts ignored
// - After wake, twenty milliseconds to settle
// - Supply monitor resets and reinitialises the converter
// - Convert rising edge samples and starts conversion
// - First two results after wake invalid
// - Conversion finishes within 101 ns
// - MSB on lane A before first edge
// - Lanes advance on both readout edges
// - Echo readout clock aligned with data
// - Dual select enables lane B, pairs
// - Pattern select substitutes fixed test words
`include "sarlv_defines.svh"
`timescale 1ns/1ps
module sarlv_top
   import sarlv_pkg::*;
#(
   parameter longint SETTLE_CYCLES = `SARLV_SETTLE_CYCLES
) (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Control pins
   input wire logic sleep_request_n,
   input wire logic supply_ok,
   input wire logic convert_start_p,
   input wire logic convert_start_n,
   input wire logic dual_lane_select,
   input wire logic pattern_select,
   // Analog core
   input wire logic [15:0] sample_code,
   output logic sample_strobe,
   output logic conv_busy,
   output logic reference_ready,
   output logic result_invalid,
   // Readout link
   input wire logic readout_clk,
   output logic echoed_clock_out,
   output logic lane_a_data,
   output logic lane_b_data,
   output logic lane_a_enable,
   output logic lane_b_enable
);

   localparam int PINS = `SARLV_PIN_COUNT;
   localparam logic [4:0] CONV_LAST = 5'(`SARLV_CONV_CYCLES - 1);
   localparam logic [22:0] SETTLE_LAST = 23'(SETTLE_CYCLES - 1);

   // Pin synchronisers
   logic [PINS-1:0] pin_raw;
   logic [PINS-1:0] pin_s1_reg;
   logic [PINS-1:0] pin_s2_reg;
   logic convert_prev_reg;

   // Control state
   sarlv_state_t state_reg;
   sarlv_state_t state_next;
   logic [4:0] conv_cnt_reg;
   logic [4:0] conv_cnt_next;
   logic [22:0] settle_cnt_reg;
   logic settle_done_reg;
   logic [1:0] inv_cnt_reg;
   logic [15:0] code_reg;
   logic code_inv_reg;

   // Output slot
   logic slot_full_reg;
   logic [15:0] tx_word_reg;
   logic tx_inv_reg;
   logic [15:0] shown_word_reg;
   logic drive_a_reg;
   logic drive_b_reg;
   logic link_hold_reg;

   // Link-side crossing
   logic [2:0] burst_s_reg;
   logic dual_l1_reg;
   logic dual_l2_reg;
   logic [2:0] fall_cnt_reg;
   logic burst_tgl_reg;

   // Named decode wires
   logic asleep;
   logic core_rst;
   logic convert_level;
   logic convert_rise;
   logic conv_done;
   logic push_valid;
   logic push_ready;
   logic pop_valid;
   logic pop_ready;
   logic [16:0] pop_data;
   logic burst_seen;
   logic [15:0] pattern_word;
   logic [3:0] edge_idx;
   logic [3:0] single_idx;
   logic [3:0] pair_hi_idx;
   logic [3:0] pair_lo_idx;
   logic [2:0] burst_last;
   logic burst_end;

   assign pin_raw[`SARLV_PIN_SLEEP_N] = sleep_request_n;
   assign pin_raw[`SARLV_PIN_SUPPLY] = supply_ok;
   assign pin_raw[`SARLV_PIN_CONVERT] = convert_start_p;
   assign pin_raw[`SARLV_PIN_CONVERT_N] = convert_start_n;
   assign pin_raw[`SARLV_PIN_DUAL] = dual_lane_select;
   assign pin_raw[`SARLV_PIN_PATTERN] = pattern_select;

   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               pin_s1_reg[gi] <= 1'b0;
               pin_s2_reg[gi] <= 1'b0;
            end else begin
               pin_s1_reg[gi] <= pin_raw[gi];
               pin_s2_reg[gi] <= pin_s1_reg[gi];
            end
         end
      end
   endgenerate

   assign core_rst = srst | ~pin_s2_reg[`SARLV_PIN_SUPPLY];
   assign asleep = ~pin_s2_reg[`SARLV_PIN_SLEEP_N];
   // Differential receiver also works with the negative leg grounded for CMOS drive
   assign convert_level = pin_s2_reg[`SARLV_PIN_CONVERT] & ~pin_s2_reg[`SARLV_PIN_CONVERT_N];
   assign convert_rise = convert_level & ~convert_prev_reg;
   assign conv_done = (state_reg == SARLV_ST_CONV) && (conv_cnt_reg == CONV_LAST);

   always_ff @(posedge sys_clk) begin
      if (core_rst) begin
         convert_prev_reg <= 1'b0;
      end else begin
         convert_prev_reg <= convert_level;
      end
   end

   // Control sequence; edges arriving during a conversion or a stalled push are dropped,
   // which is safe while the host keeps its cycle period
   always_comb begin
      state_next = state_reg;
      conv_cnt_next = conv_cnt_reg;
      case (state_reg)
         SARLV_ST_OFF: begin
            if (!asleep) begin
               state_next = SARLV_ST_IDLE;
            end
         end
         SARLV_ST_IDLE: begin
            if (asleep) begin
               state_next = SARLV_ST_OFF;
            end else if (convert_rise) begin
               state_next = SARLV_ST_CONV;
               conv_cnt_next = 5'h00;
            end
         end
         SARLV_ST_CONV: begin
            conv_cnt_next = conv_cnt_reg + 5'h01;
            if (asleep) begin
               state_next = SARLV_ST_OFF;
            end else if (conv_done) begin
               state_next = SARLV_ST_PUSH;
            end
         end
         SARLV_ST_PUSH: begin
            if (asleep) begin
               state_next = SARLV_ST_OFF;
            end else if (push_ready) begin
               state_next = SARLV_ST_IDLE;
            end
         end
         default: begin
            state_next = SARLV_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (core_rst) begin
         state_reg <= SARLV_ST_OFF;
         conv_cnt_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         conv_cnt_reg <= conv_cnt_next;
      end
   end

   // Analog core hands over its decided code on the last conversion cycle
   always_ff @(posedge sys_clk) begin
      if (core_rst) begin
         code_reg <= 16'h0000;
         code_inv_reg <= 1'b1;
      end else if (conv_done) begin
         code_reg <= sample_code;
         code_inv_reg <= (inv_cnt_reg != `SARLV_INVALID_COUNT);
      end
   end

   // Count valid-warming conversions since reset or wake
   always_ff @(posedge sys_clk) begin
      if (core_rst || asleep) begin
         inv_cnt_reg <= 2'h0;
      end else if (conv_done && inv_cnt_reg != `SARLV_INVALID_COUNT) begin
         inv_cnt_reg <= inv_cnt_reg + 2'h1;
      end
   end

   // Reference settling timer; only flags readiness, conversions are not blocked
   always_ff @(posedge sys_clk) begin
      if (core_rst || asleep) begin
         settle_cnt_reg <= 23'h000000;
         settle_done_reg <= 1'b0;
      end else if (!settle_done_reg) begin
         settle_cnt_reg <= settle_cnt_reg + 23'h000001;
         settle_done_reg <= (settle_cnt_reg == SETTLE_LAST);
      end
   end

   // Results wait here when the host falls behind; a full buffer stalls the push state
   assign push_valid = (state_reg == SARLV_ST_PUSH);

   sarlv_fifo #(
      .WIDTH(17),
      .DEPTH(`SARLV_FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .srst(core_rst | asleep),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data({code_inv_reg, code_reg}),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_data)
   );

   // Burst completion crosses back as a toggle
   assign burst_seen = burst_s_reg[2] ^ burst_s_reg[1];
   assign pop_ready = ~slot_full_reg | burst_seen;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         burst_s_reg <= 3'h0;
      end else begin
         burst_s_reg <= {burst_s_reg[1:0], burst_tgl_reg};
      end
   end

   // The slot word only changes at completion or while the slot is empty; the host reads it between completions
   always_ff @(posedge sys_clk) begin
      if (core_rst || asleep) begin
         slot_full_reg <= 1'b0;
         tx_word_reg <= 16'h0000;
         tx_inv_reg <= 1'b1;
      end else if (pop_valid && pop_ready) begin
         slot_full_reg <= 1'b1;
         tx_word_reg <= pop_data[15:0];
         tx_inv_reg <= pop_data[16];
      end else if (burst_seen) begin
         slot_full_reg <= 1'b0;
      end
   end

   assign pattern_word = pin_s2_reg[`SARLV_PIN_DUAL] ? `SARLV_PATTERN_DUAL : `SARLV_PATTERN_SINGLE;

   always_ff @(posedge sys_clk) begin
      if (core_rst) begin
         shown_word_reg <= 16'h0000;
         drive_a_reg <= 1'b0;
         drive_b_reg <= 1'b0;
         link_hold_reg <= 1'b1;
      end else begin
         shown_word_reg <= pin_s2_reg[`SARLV_PIN_PATTERN] ? pattern_word : tx_word_reg;
         drive_a_reg <= ~asleep;
         drive_b_reg <= ~asleep & pin_s2_reg[`SARLV_PIN_DUAL];
         link_hold_reg <= asleep;
      end
   end

   // Link domain: counts falling edges only, so the count wraps with the burst and
   // needs no edge outside it. The hold clears it at once, as the link clock is idle
   // between bursts; limitation: the host must not clock the link while waking
   always_ff @(negedge readout_clk) begin
      dual_l1_reg <= drive_b_reg;
      dual_l2_reg <= dual_l1_reg;
   end

   assign burst_last = dual_l2_reg ? `SARLV_LAST_PULSE_DUAL : `SARLV_LAST_PULSE_SINGLE;
   assign burst_end = (fall_cnt_reg == burst_last);

   always_ff @(negedge readout_clk or posedge link_hold_reg) begin
      if (link_hold_reg) begin
         fall_cnt_reg <= 3'h0;
         burst_tgl_reg <= 1'b0;
      end else if (burst_end) begin
         fall_cnt_reg <= 3'h0;
         burst_tgl_reg <= ~burst_tgl_reg;
      end else begin
         fall_cnt_reg <= fall_cnt_reg + 3'h1;
      end
   end

   // Edge index: the clock level itself counts the rising half, so data moves on both edges
   assign edge_idx = {fall_cnt_reg, readout_clk};
   assign single_idx = ~edge_idx;
   assign pair_hi_idx = {~edge_idx[2:0], 1'b1};
   assign pair_lo_idx = {~edge_idx[2:0], 1'b0};

   // Index zero before the first edge puts the most significant bit out
   assign lane_a_data = drive_a_reg & (drive_b_reg ? shown_word_reg[pair_hi_idx] : shown_word_reg[single_idx]);
   assign lane_b_data = drive_b_reg & shown_word_reg[pair_lo_idx];
   assign echoed_clock_out = drive_a_reg & readout_clk;
   assign lane_a_enable = drive_a_reg;
   assign lane_b_enable = drive_b_reg;

   // Status to the analog core and host
   assign sample_strobe = (state_reg == SARLV_ST_IDLE) & ~asleep & convert_rise;
   assign conv_busy = (state_reg == SARLV_ST_CONV);
   assign reference_ready = settle_done_reg;
   assign result_invalid = tx_inv_reg;

endmodule

// *** verification/sarlv_checker.sv ***
// Port-level assertions for the converter control and readout block.
// Assumes the bind hands on the instance's SETTLE_CYCLES.
`timescale 1ns/1ps
module sarlv_checker #(
   parameter longint SETTLE_CYCLES = 50
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Control pins
   input wire logic sleep_request_n,
   input wire logic supply_ok,
   input wire logic dual_lane_select,
   // Core and link outputs
   input wire logic sample_strobe,
   input wire logic conv_busy,
   input wire logic reference_ready,
   input wire logic result_invalid,
   input wire logic readout_clk,
   input wire logic echoed_clock_out,
   input wire logic lane_a_enable,
   input wire logic lane_b_enable
);
   logic [31:0] busy_cnt_reg;
   logic [31:0] awake_cnt_reg;
   wire awake = sleep_request_n && supply_ok;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Raw pins are counted, so the design's synced view always lags this count
   always_ff @(posedge sys_clk) begin
      busy_cnt_reg <= conv_busy ? busy_cnt_reg + 32'h1 : 32'h0;
      awake_cnt_reg <= (srst || !awake) ? 32'h0 : awake_cnt_reg + 32'h1;
   end
   a_sleep_drivers_off: assert property (
      $fell(sleep_request_n) |-> ##[1:4] (!lane_a_enable && !lane_b_enable)) else $error("drivers on in sleep");
   a_sleep_no_convert: assert property (
      (!sleep_request_n) [*4] |-> !sample_strobe) else $error("convert taken in sleep");
   a_strobe_starts_busy: assert property (
      sample_strobe |=> conv_busy) else $error("strobe without conversion");
   a_busy_not_retaken: assert property (
      conv_busy |-> !sample_strobe) else $error("convert taken while busy");
   a_conv_length: assert property (
      $fell(conv_busy) |-> busy_cnt_reg == 32'd25) else $error("conversion length wrong");
   a_settle_not_early: assert property (
      $rose(reference_ready) |-> awake_cnt_reg >= SETTLE_CYCLES) else $error("reference ready early");
   a_settle_bounded: assert property (
      awake_cnt_reg == SETTLE_CYCLES + 8 |-> reference_ready) else $error("reference ready late");
   a_supply_holds_core: assert property (
      (!supply_ok) [*4] |-> (!conv_busy && !reference_ready && result_invalid)) else $error("supply reset lost");
   a_reset_marks_invalid: assert property (
      $fell(srst) |-> result_invalid) else $error("first result not invalid");
   a_lane_b_dual: assert property (
      (dual_lane_select && lane_a_enable) [*4] |-> lane_b_enable) else $error("second lane off");
   a_echo_gated: assert property (
      !lane_a_enable |-> !echoed_clock_out) else $error("echo while off");
   a_echo_follows: assert property (
      lane_a_enable && $past(lane_a_enable) |-> echoed_clock_out == readout_clk) else $error("echo differs");
endmodule
bind sarlv_top sarlv_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (
   .sys_clk(sys_clk),
   .srst(srst),
   .sleep_request_n(sleep_request_n),
   .supply_ok(supply_ok),
   .dual_lane_select(dual_lane_select),
   .sample_strobe(sample_strobe),
   .conv_busy(conv_busy),
   .reference_ready(reference_ready),
   .result_invalid(result_invalid),
   .readout_clk(readout_clk),
   .echoed_clock_out(echoed_clock_out),
   .lane_a_enable(lane_a_enable),
   .lane_b_enable(lane_b_enable)
);

// *** verification/sarlv_host_model.sv ***
// Host capture logic: drives readout bursts at 64 ns and gathers the word.
// Assumes the caller keeps mode pins still for the whole burst.
`timescale 1ns/1ps
module sarlv_host_model (
   // Link
   output logic readout_clk,
   input wire logic lane_a_data,
   input wire logic lane_b_data
);
   // Clock stands low between bursts
   initial readout_clk = 1'b0;
   // Each bit is taken just before the edge that retires it; gap stretches the high phase
   task automatic burst(input int pulses, input bit dual, input int gap, output logic [15:0] word);
      int i;
      word = 16'h0;
      // Offset keeps link edges off the system clock grid
      #1.3;
      for (i = 0; i < 2 * pulses; i++) begin
         #(32 + ((i % 2) ? gap : 0));
         if (dual) word = {word[13:0], lane_a_data, lane_b_data};
         else word = {word[14:0], lane_a_data};
         readout_clk = ~readout_clk;
      end
      #32;
   endtask
endmodule

// *** verification/tb.sv ***
// Bench: random conversions read out in both lane modes, with wake and supply cycles.
// Assumes the host model drives the link; settle count shortened to 50.
`include "sarlv_defines.svh"
`timescale 1ns/1ps
module tb;
   localparam longint SETTLE = 50;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic sleep_request_n = 1'b0;
   logic supply_ok = 1'b1;
   logic convert_start_p = 1'b0;
   logic convert_start_n = 1'b0;
   logic dual_lane_select = 1'b0;
   logic pattern_select = 1'b0;
   bit lvds = 1'b0;
   logic [15:0] sample_code = 16'h0;
   logic sample_strobe, conv_busy, reference_ready, result_invalid;
   logic readout_clk, echoed_clock_out, lane_a_data, lane_b_data, lane_a_enable, lane_b_enable;
   int num_errors = 0;
   int total_checks = 0;
   always #2 sys_clk = ~sys_clk;
   sarlv_top #(.SETTLE_CYCLES(SETTLE)) uut (
      .sys_clk(sys_clk), .srst(srst), .sleep_request_n(sleep_request_n), .supply_ok(supply_ok),
      .convert_start_p(convert_start_p), .convert_start_n(convert_start_n),
      .dual_lane_select(dual_lane_select), .pattern_select(pattern_select), .sample_code(sample_code),
      .sample_strobe(sample_strobe), .conv_busy(conv_busy), .reference_ready(reference_ready),
      .result_invalid(result_invalid), .readout_clk(readout_clk), .echoed_clock_out(echoed_clock_out),
      .lane_a_data(lane_a_data), .lane_b_data(lane_b_data), .lane_a_enable(lane_a_enable),
      .lane_b_enable(lane_b_enable));
   sarlv_host_model host (.readout_clk(readout_clk), .lane_a_data(lane_a_data), .lane_b_data(lane_b_data));
   task automatic finish_test;
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0, got}, {15'h0, exp});
   endtask
   function automatic logic [15:0] exp_word(input logic [15:0] c, input logic dual, input logic pat);
      if (!pat) return c;
      return dual ? `SARLV_PATTERN_DUAL : `SARLV_PATTERN_SINGLE;
   endfunction
   // how: 0 leave sleep, 1 sleep then wake, 2 supply drop then return
   task automatic wake(input int how);
      int t;
      @(negedge sys_clk);
      if (how == 1) sleep_request_n = 1'b0;
      if (how == 2) supply_ok = 1'b0;
      repeat (10) @(negedge sys_clk);
      sleep_request_n = 1'b1;
      supply_ok = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk1(reference_ready, 1'b0);
      t = 0;
      while (reference_ready !== 1'b1 && t < SETTLE + 20) begin
         @(negedge sys_clk);
         t++;
      end
      chk1(reference_ready, 1'b1);
   endtask
   task automatic convert(input logic [15:0] c);
      int t;
      @(negedge sys_clk);
      sample_code = c;
      convert_start_p = 1'b1;
      convert_start_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      convert_start_p = 1'b0;
      convert_start_n = lvds;
      t = 0;
      while (conv_busy !== 1'b0 && t < 40) begin
         @(negedge sys_clk);
         t++;
      end
      chk1(conv_busy, 1'b0);
   endtask
   task automatic readout(input logic [15:0] exp, input logic inv, input int gap);
      logic [15:0] w;
      repeat (8) @(negedge sys_clk);
      chk1(result_invalid, inv);
      chk1(lane_b_enable, dual_lane_select);
      host.burst(dual_lane_select ? 4 : 8, dual_lane_select, gap, w);
      chk16(w, exp);
   endtask
   initial begin
      int k, ph, gap, d;
      bit ov;
      logic [15:0] c, nc;
      void'($urandom(32'hb3feb617));
      repeat (5) @(negedge sys_clk);
      srst = 1'b0;
      // Readout edges while asleep must leave the link count at a burst start
      host.burst(3, 1'b0, 0, c);
      convert(16'h1234);
      chk1(lane_a_enable, 1'b0);
      for (ph = 0; ph < 3; ph++) begin
         // Middle phase drives the convert pins as a differential pair
         lvds = (ph == 1);
         wake(ph);
         c = 16'($urandom);
         convert(c);
         for (k = 0; k < 8; k++) begin
            nc = 16'($urandom);
            ov = 1'($urandom);
            gap = (k == 3) ? 40 : 0;
            @(negedge sys_clk);
            dual_lane_select = (k > 4) ? k[0] : 1'($urandom);
            pattern_select = (k == 5 || k == 6);
            // Next convert lands late so it completes only after this burst ends
            d = (dual_lane_select ? 4 : 8) * (64 + gap) - 30;
            fork
               readout(exp_word(c, dual_lane_select, pattern_select), k < 2, gap);
               if (ov) begin
                  #(d);
                  convert(nc);
               end
            join
            if (!ov) convert(nc);
            c = nc;
         end
      end
      finish_test;
   end
   // About 15 us of traffic expected; over ten times that means a hang
   initial begin
      #200000;
      num_errors++;
      finish_test;
   end
endmodule
